// ### inc/rfa_pkg.sv
// Shared constants and types of the register field access bank
package rfa_pkg;

    localparam int DATA_W  = 32;
    localparam int FIELD_W = 16;
    localparam int OFS_W   = 12;
    localparam int NUM_REG = 8;
    localparam int IDX_W   = 3;
    localparam int SYNC_STAGES = 2;

    typedef enum {
        RFA_RW,
        RFA_RO,
        RFA_RC,
        RFA_RWC,
        RFA_RW1C,
        RFA_RW1S,
        RFA_W1C,
        RFA_WO
    } rfa_access_t;

    // Byte offsets from the module base address
    localparam logic [OFS_W-1:0] OFS_RW   = 12'h000;
    localparam logic [OFS_W-1:0] OFS_RO   = 12'h004;
    localparam logic [OFS_W-1:0] OFS_RC   = 12'h008;
    localparam logic [OFS_W-1:0] OFS_RWC  = 12'h00C;
    localparam logic [OFS_W-1:0] OFS_RW1C = 12'h010;
    localparam logic [OFS_W-1:0] OFS_RW1S = 12'h014;
    localparam logic [OFS_W-1:0] OFS_W1C  = 12'h018;
    localparam logic [OFS_W-1:0] OFS_WO   = 12'h01C;

    // Field reset values
    localparam logic [FIELD_W-1:0] RST_RW   = 16'h00A5;
    localparam logic [FIELD_W-1:0] RST_RO   = 16'h0000;
    localparam logic [FIELD_W-1:0] RST_RC   = 16'h0000;
    localparam logic [FIELD_W-1:0] RST_RWC  = 16'h0000;
    localparam logic [FIELD_W-1:0] RST_RW1C = 16'h0000;
    localparam logic [FIELD_W-1:0] RST_RW1S = 16'h0001;
    localparam logic [FIELD_W-1:0] RST_W1C  = 16'h0000;
    localparam logic [FIELD_W-1:0] RST_WO   = 16'h0000;

    // Index order of the bank
    localparam logic [IDX_W-1:0] IDX_RW   = 3'h0;
    localparam logic [IDX_W-1:0] IDX_RO   = 3'h1;
    localparam logic [IDX_W-1:0] IDX_RC   = 3'h2;
    localparam logic [IDX_W-1:0] IDX_RWC  = 3'h3;
    localparam logic [IDX_W-1:0] IDX_RW1C = 3'h4;
    localparam logic [IDX_W-1:0] IDX_RW1S = 3'h5;
    localparam logic [IDX_W-1:0] IDX_W1C  = 3'h6;
    localparam logic [IDX_W-1:0] IDX_WO   = 3'h7;

    localparam rfa_access_t ACC_MAP [NUM_REG] = '{
        RFA_RW, RFA_RO, RFA_RC, RFA_RWC,
        RFA_RW1C, RFA_RW1S, RFA_W1C, RFA_WO};
    localparam logic [OFS_W-1:0] OFS_MAP [NUM_REG] = '{
        OFS_RW, OFS_RO, OFS_RC, OFS_RWC,
        OFS_RW1C, OFS_RW1S, OFS_W1C, OFS_WO};
    localparam logic [FIELD_W-1:0] RST_MAP [NUM_REG] = '{
        RST_RW, RST_RO, RST_RC, RST_RWC,
        RST_RW1C, RST_RW1S, RST_W1C, RST_WO};

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rfa_req_t;

    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] rdata;
    } rfa_rsp_t;

    // Hardware side events, all one-cycle pulses per bit
    typedef struct packed {
        logic [FIELD_W-1:0] rc_set;
        logic [FIELD_W-1:0] rwc_set;
        logic [FIELD_W-1:0] rw1c_set;
        logic [FIELD_W-1:0] w1c_set;
        logic [FIELD_W-1:0] rw1s_clr;
    } rfa_hw_t;

    typedef struct packed {
        logic             hit;
        logic [IDX_W-1:0] idx;
    } rfa_dec_t;

    function automatic rfa_dec_t rfa_decode(input logic [DATA_W-1:0] ofs);
        rfa_dec_t d;
        d = '0;
        for (int i = 0; i < NUM_REG; i++) begin
            if (ofs == {20'h00000, OFS_MAP[i]}) begin
                d.hit = 1'b1;
                d.idx = IDX_W'(i);
            end
        end
        return d;
    endfunction : rfa_decode

endpackage : rfa_pkg

// ### verilog/rfa_sync.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/100ps
module rfa_sync #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    always_comb begin
        meta_next = din;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg;
endmodule : rfa_sync

// ### verilog/rfa_field.sv
// One register field with a selectable software access type
`timescale 1ns/100ps
module rfa_field #(
    parameter rfa_pkg::rfa_access_t ACCESS  = rfa_pkg::RFA_RW,
    parameter int                   W       = 16,
    parameter logic [W-1:0]         RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         wr_en,
    input  wire logic         rd_en,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] hw_in,
    output logic      [W-1:0] value,
    output logic      [W-1:0] rdata
);
    logic [W-1:0] val_reg;
    logic [W-1:0] val_next;

    // hw_in: set pulses, clear pulses for W1S, or live value for RO
    always_comb begin
        val_next = val_reg;
        rdata    = val_reg;
        case (ACCESS)
            rfa_pkg::RFA_RW:   if (wr_en) val_next = wdata;
            rfa_pkg::RFA_RO:   val_next = hw_in;
            rfa_pkg::RFA_RC:   // Set wins over read clear
                val_next = (rd_en ? '0 : val_reg) | hw_in;
            rfa_pkg::RFA_RWC:
                val_next = (wr_en ? '0 : val_reg) | hw_in;
            rfa_pkg::RFA_RW1C:
                val_next = (wr_en ? val_reg & ~wdata : val_reg) | hw_in;
            rfa_pkg::RFA_RW1S:
                val_next = (val_reg & ~hw_in) | (wr_en ? wdata : '0);
            rfa_pkg::RFA_W1C: begin
                val_next = (wr_en ? val_reg & ~wdata : val_reg) | hw_in;
                rdata    = '0;
            end
            rfa_pkg::RFA_WO: begin
                if (wr_en) val_next = wdata;
                rdata = '0;
            end
            default: val_next = val_reg;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            val_reg <= RST_VAL;
        end else begin
            val_reg <= val_next;
        end
    end

    assign value = val_reg;
endmodule : rfa_field

// ### verilog/rfa_bank.sv
// Register bank exercising every software field access type
`timescale 1ns/100ps
// Operation
// - Clear-on-read returns value, then clears
// - Read/write field stores and returns writes
// - Any write clears clear-on-write field
// - Readable write-one-to-clear clears only ones
// - Write-one-to-set sets ones, readable anytime
// - Write-only one-to-clear clears flags, reads meaningless
// - Write-only field accepts writes, reads meaningless
// - Every field takes its reset value
// - Reserved bits read zero, software preserves
// - Registers decoded at base plus offset
module rfa_bank #(
    parameter logic [31:0] BASE_ADDR = 32'h4000_0000
) (
    input  wire logic                         SYS_CLK,
    input  wire logic                         RESET,
    input  wire rfa_pkg::rfa_req_t            ACC_REQ,
    output rfa_pkg::rfa_rsp_t                 ACC_RSP,
    input  wire rfa_pkg::rfa_hw_t             HW_EVT,
    input  wire logic [rfa_pkg::FIELD_W-1:0]  HW_STATUS,
    output logic      [rfa_pkg::FIELD_W-1:0]  CTRL_RW,
    output logic      [rfa_pkg::FIELD_W-1:0]  CTRL_W1S,
    output logic      [rfa_pkg::FIELD_W-1:0]  CTRL_WO,
    output logic      [rfa_pkg::FIELD_W-1:0]  FLAG_W1C
);
    localparam int FW = rfa_pkg::FIELD_W;
    localparam int DW = rfa_pkg::DATA_W;
    localparam int NR = rfa_pkg::NUM_REG;

    logic [DW-1:0]     offset;
    rfa_pkg::rfa_dec_t dec;
    logic [NR-1:0]     wr_en;
    logic [NR-1:0]     rd_en;
    logic [FW-1:0]     hw_in    [NR];
    logic [FW-1:0]     fld_val  [NR];
    logic [FW-1:0]     fld_rd   [NR];
    logic [FW-1:0]     status_sync;
    rfa_pkg::rfa_rsp_t rsp_reg;
    rfa_pkg::rfa_rsp_t rsp_next;

    // Status pins come from outside the clock domain
    rfa_sync #(
        .W (FW)
    ) u_sync (
        .clk  (SYS_CLK),
        .rst  (RESET),
        .din  (HW_STATUS),
        .dout (status_sync)
    );

    // Misaligned or foreign addresses never hit
    always_comb begin
        offset = ACC_REQ.addr - BASE_ADDR;
        dec    = rfa_pkg::rfa_decode(offset);
        for (int i = 0; i < NR; i++) begin
            wr_en[i] = ACC_REQ.valid & ACC_REQ.write & dec.hit
                       & (dec.idx == rfa_pkg::IDX_W'(i));
            rd_en[i] = ACC_REQ.valid & ~ACC_REQ.write & dec.hit
                       & (dec.idx == rfa_pkg::IDX_W'(i));
        end
    end

    always_comb begin
        for (int i = 0; i < NR; i++) begin
            hw_in[i] = '0;
        end
        hw_in[rfa_pkg::IDX_RO]   = status_sync;
        hw_in[rfa_pkg::IDX_RC]   = HW_EVT.rc_set;
        hw_in[rfa_pkg::IDX_RWC]  = HW_EVT.rwc_set;
        hw_in[rfa_pkg::IDX_RW1C] = HW_EVT.rw1c_set;
        hw_in[rfa_pkg::IDX_RW1S] = HW_EVT.rw1s_clr;
        hw_in[rfa_pkg::IDX_W1C]  = HW_EVT.w1c_set;
    end

    for (genvar g = 0; g < NR; g++) begin : g_fld
        rfa_field #(
            .ACCESS  (rfa_pkg::ACC_MAP[g]),
            .W       (FW),
            .RST_VAL (rfa_pkg::RST_MAP[g])
        ) u_fld (
            .clk   (SYS_CLK),
            .rst   (RESET),
            .wr_en (wr_en[g]),
            .rd_en (rd_en[g]),
            .wdata (ACC_REQ.wdata[FW-1:0]),
            .hw_in (hw_in[g]),
            .value (fld_val[g]),
            .rdata (fld_rd[g])
        );
    end

    // Read data captured on the same edge that a read clear acts
    always_comb begin
        rsp_next       = '0;
        rsp_next.ack   = ACC_REQ.valid;
        if (ACC_REQ.valid && !ACC_REQ.write && dec.hit) begin
            rsp_next.rdata = {{(DW-FW){1'b0}}, fld_rd[dec.idx]};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    assign ACC_RSP  = rsp_reg;
    assign CTRL_RW  = fld_val[rfa_pkg::IDX_RW];
    assign CTRL_W1S = fld_val[rfa_pkg::IDX_RW1S];
    assign CTRL_WO  = fld_val[rfa_pkg::IDX_WO];
    assign FLAG_W1C = fld_val[rfa_pkg::IDX_W1C];

    // Checks
    logic          req_rd;
    logic          req_wr;
    logic [FW-1:0] wd;
    assign req_rd = ACC_REQ.valid & ~ACC_REQ.write;
    assign req_wr = ACC_REQ.valid & ACC_REQ.write;
    assign wd     = ACC_REQ.wdata[FW-1:0];

    // Short names for the internal fields
    logic [FW-1:0] ro_val;
    logic [FW-1:0] rc_val;
    logic [FW-1:0] rwc_val;
    logic [FW-1:0] rw1c_val;
    assign ro_val   = fld_val[rfa_pkg::IDX_RO];
    assign rc_val   = fld_val[rfa_pkg::IDX_RC];
    assign rwc_val  = fld_val[rfa_pkg::IDX_RWC];
    assign rw1c_val = fld_val[rfa_pkg::IDX_RW1C];

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    rw_store_a: assert property (
        wr_en[rfa_pkg::IDX_RW] |=> CTRL_RW == $past(wd))
        else $error("read/write field lost written data");

    rw_read_a: assert property (
        rd_en[rfa_pkg::IDX_RW] |=>
            ACC_RSP.ack && ACC_RSP.rdata == {16'h0000, $past(CTRL_RW)})
        else $error("read/write field read back wrong");

    rc_value_a: assert property (
        rd_en[rfa_pkg::IDX_RC] |=>
            ACC_RSP.rdata[FW-1:0] == $past(fld_val[rfa_pkg::IDX_RC]))
        else $error("clear-on-read field returned wrong value");

    rc_clear_a: assert property (
        rd_en[rfa_pkg::IDX_RC] |=>
            fld_val[rfa_pkg::IDX_RC] == $past(HW_EVT.rc_set))
        else $error("clear-on-read field not cleared by read");

    ro_keep_a: assert property (
        wr_en[rfa_pkg::IDX_RO] |=>
            fld_val[rfa_pkg::IDX_RO] == $past(status_sync))
        else $error("read-only field changed by write");

    wc_clear_a: assert property (
        wr_en[rfa_pkg::IDX_RWC] |=>
            fld_val[rfa_pkg::IDX_RWC] == $past(HW_EVT.rwc_set))
        else $error("clear-on-write field not cleared");

    w1c_clear_a: assert property (
        wr_en[rfa_pkg::IDX_RW1C] |=>
            fld_val[rfa_pkg::IDX_RW1C] ==
            (($past(fld_val[rfa_pkg::IDX_RW1C]) & ~$past(wd))
             | $past(HW_EVT.rw1c_set)))
        else $error("write-one-to-clear field wrong after write");

    w1s_set_a: assert property (
        wr_en[rfa_pkg::IDX_RW1S] |=>
            CTRL_W1S == (($past(CTRL_W1S) & ~$past(HW_EVT.rw1s_clr))
                         | $past(wd)))
        else $error("write-one-to-set field wrong after write");

    wo1c_flag_a: assert property (
        wr_en[rfa_pkg::IDX_W1C] && (wd & HW_EVT.w1c_set) == 16'h0000 |=>
            (FLAG_W1C & $past(wd)) == 16'h0000)
        else $error("write-only flag not cleared by one");

    wo_read_a: assert property (
        rd_en[rfa_pkg::IDX_W1C] || rd_en[rfa_pkg::IDX_WO] |=>
            ACC_RSP.rdata == 32'h0000_0000)
        else $error("write-only register read not zero");

    wo_store_a: assert property (
        wr_en[rfa_pkg::IDX_WO] |=> CTRL_WO == $past(wd))
        else $error("write-only field lost written data");

    reset_val_a: assert property (@(posedge SYS_CLK)
        $past(RESET) && !RESET |->
            CTRL_RW == rfa_pkg::RST_RW && CTRL_W1S == rfa_pkg::RST_RW1S
            && FLAG_W1C == rfa_pkg::RST_W1C && ACC_RSP == '0
            && CTRL_WO == rfa_pkg::RST_WO)
        else $error("field not at reset value after reset");

    unmapped_a: assert property (
        req_rd && !dec.hit |=> ACC_RSP.ack && ACC_RSP.rdata == 32'h0)
        else $error("unmapped read returned data");

    reserved_a: assert property (
        req_rd |=> ACC_RSP.ack && ACC_RSP.rdata[DW-1:FW] == 16'h0000)
        else $error("reserved bits read nonzero");

    idle_a: assert property (
        !ACC_REQ.valid |=> !ACC_RSP.ack)
        else $error("answer without request");

    // Between accesses only hardware events move a field
    rw_hold_a: assert property (
        !wr_en[rfa_pkg::IDX_RW] |=> $stable(CTRL_RW))
        else $error("read/write field changed without a write");

    wo_hold_a: assert property (
        !wr_en[rfa_pkg::IDX_WO] |=> $stable(CTRL_WO))
        else $error("write-only field changed without a write");

    rc_hold_a: assert property (
        !rd_en[rfa_pkg::IDX_RC] |=>
            rc_val == ($past(rc_val) | $past(HW_EVT.rc_set)))
        else $error("clear-on-read field changed without a read");

    rwc_hold_a: assert property (
        !wr_en[rfa_pkg::IDX_RWC] |=>
            rwc_val == ($past(rwc_val) | $past(HW_EVT.rwc_set)))
        else $error("clear-on-write field changed without a write");

    w1c_hold_a: assert property (
        !wr_en[rfa_pkg::IDX_RW1C] |=>
            rw1c_val == ($past(rw1c_val) | $past(HW_EVT.rw1c_set)))
        else $error("write-one-to-clear field changed without a write");

    w1s_hold_a: assert property (
        !wr_en[rfa_pkg::IDX_RW1S] |=>
            CTRL_W1S == ($past(CTRL_W1S) & ~$past(HW_EVT.rw1s_clr)))
        else $error("write-one-to-set field changed without a write");

    flag_hold_a: assert property (
        !wr_en[rfa_pkg::IDX_W1C] |=>
            FLAG_W1C == ($past(FLAG_W1C) | $past(HW_EVT.w1c_set)))
        else $error("write-only flag changed without a write");

    flag_write_a: assert property (
        wr_en[rfa_pkg::IDX_W1C] |=>
            FLAG_W1C == (($past(FLAG_W1C) & ~$past(wd))
                         | $past(HW_EVT.w1c_set)))
        else $error("write-only flag wrong after write");

    // Skip edges whose history still holds pre-reset values
    ro_follow_a: assert property (
        !$past(RESET) |-> ro_val == $past(status_sync))
        else $error("read-only field does not follow the status");

    sync_path_a: assert property (
        !$past(RESET) && !$past(RESET, 2) |->
            status_sync == $past(HW_STATUS, 2))
        else $error("status not passed through two flops");

    // Reads return the value held at the taking edge
    ro_read_a: assert property (
        rd_en[rfa_pkg::IDX_RO] |=>
            ACC_RSP.rdata == {16'h0000, $past(ro_val)})
        else $error("read-only field read back wrong");

    rwc_read_a: assert property (
        rd_en[rfa_pkg::IDX_RWC] |=>
            ACC_RSP.rdata == {16'h0000, $past(rwc_val)})
        else $error("clear-on-write field read back wrong");

    w1c_read_a: assert property (
        rd_en[rfa_pkg::IDX_RW1C] |=>
            ACC_RSP.rdata == {16'h0000, $past(rw1c_val)})
        else $error("write-one-to-clear field read back wrong");

    w1s_read_a: assert property (
        rd_en[rfa_pkg::IDX_RW1S] |=>
            ACC_RSP.rdata == {16'h0000, $past(CTRL_W1S)})
        else $error("write-one-to-set field read back wrong");

    // Every request answered once, writes with no data
    wr_ack_a: assert property (
        req_wr |=> ACC_RSP.ack && ACC_RSP.rdata == 32'h0000_0000)
        else $error("write answered without ack or with data");

    req_ack_a: assert property (
        ACC_REQ.valid |=> ACC_RSP.ack)
        else $error("request not answered");

    idle_data_a: assert property (
        !ACC_REQ.valid |=> ACC_RSP.rdata == 32'h0000_0000)
        else $error("read data without request");

    miss_wr_a: assert property (
        req_wr && !dec.hit |=> $stable(CTRL_RW) && $stable(CTRL_WO))
        else $error("unmapped write changed a field");

    aligned_hit_a: assert property (
        dec.hit |-> offset[1:0] == 2'h0)
        else $error("decode hit on a misaligned offset");

    miss_quiet_a: assert property (
        !dec.hit |-> wr_en == 8'h00 && rd_en == 8'h00)
        else $error("unmapped access enabled a field");

    one_sel_a: assert property (
        dec.hit |-> $onehot0(wr_en | rd_en))
        else $error("access enabled more than one field");

    rc_read_c: cover property (
        HW_EVT.rc_set != 16'h0000 ##2 rd_en[rfa_pkg::IDX_RC]);
    rc_race_c: cover property (
        rd_en[rfa_pkg::IDX_RC] && HW_EVT.rc_set != 16'h0000);
    w1c_back_c: cover property (
        rd_en[rfa_pkg::IDX_RW1C] ##2 wr_en[rfa_pkg::IDX_RW1C]);
    w1s_race_c: cover property (
        wr_en[rfa_pkg::IDX_RW1S] && HW_EVT.rw1s_clr != 16'h0000);
    wr_any_c: cover property (req_wr && !dec.hit);
endmodule : rfa_bank

// ### verif/rfa_bank_bench.sv
// Self-checking bench for the register field access bank
`timescale 1ns/100ps
module rfa_bank_bench;
    localparam logic [31:0] BASE_ADDR = 32'h4000_0000;

    typedef struct packed {
        logic        wr;
        logic [11:0] ofs;
        logic [31:0] wd;
        logic [31:0] exp;
    } rfa_row_t;

    logic                  SYS_CLK;
    logic                  RESET;
    rfa_pkg::rfa_req_t     ACC_REQ;
    rfa_pkg::rfa_rsp_t     ACC_RSP;
    rfa_pkg::rfa_hw_t      HW_EVT;
    logic [15:0]           HW_STATUS;
    logic [15:0]           CTRL_RW;
    logic [15:0]           CTRL_W1S;
    logic [15:0]           CTRL_WO;
    logic [15:0]           FLAG_W1C;
    int                    miscompares;
    int                    samples_checked;
    logic [31:0]           rd;
    rfa_pkg::rfa_hw_t      ev;

    // Ordinary cases run in order; later rows lean on earlier ones
    localparam rfa_row_t ROWS [22] = '{
        '{1'b0, 12'h000, 32'h0, 32'h0000_00A5},
        '{1'b1, 12'h000, 32'h0000_1234, 32'h0},
        '{1'b0, 12'h000, 32'h0, 32'h0000_1234},
        '{1'b0, 12'h014, 32'h0, 32'h0000_0001},
        '{1'b1, 12'h014, 32'h0000_00F0, 32'h0},
        '{1'b1, 12'h014, 32'h0000_0000, 32'h0},
        '{1'b0, 12'h014, 32'h0, 32'h0000_00F1},
        '{1'b0, 12'h008, 32'h0, 32'h0},
        '{1'b0, 12'h00C, 32'h0, 32'h0},
        '{1'b0, 12'h010, 32'h0, 32'h0},
        '{1'b0, 12'h018, 32'h0, 32'h0},
        '{1'b1, 12'h01C, 32'h0000_5A5A, 32'h0},
        '{1'b0, 12'h01C, 32'h0, 32'h0},
        '{1'b1, 12'h020, 32'h0000_FFFF, 32'h0},
        '{1'b1, 12'h002, 32'h0000_FFFF, 32'h0},
        '{1'b0, 12'h020, 32'h0, 32'h0},
        '{1'b0, 12'h000, 32'h0, 32'h0000_1234},
        '{1'b1, 12'h000, 32'hFFFF_00FF, 32'h0},
        '{1'b0, 12'h000, 32'h0, 32'h0000_00FF},
        '{1'b1, 12'h004, 32'h0000_0000, 32'h0},
        '{1'b1, 12'h004, 32'h0000_FFFF, 32'h0},
        '{1'b0, 12'h004, 32'h0, 32'h0000_3C3C}};

    rfa_bank #(
        .BASE_ADDR (BASE_ADDR)
    ) rfa_bank_i (
        .SYS_CLK   (SYS_CLK),
        .RESET     (RESET),
        .ACC_REQ   (ACC_REQ),
        .ACC_RSP   (ACC_RSP),
        .HW_EVT    (HW_EVT),
        .HW_STATUS (HW_STATUS),
        .CTRL_RW   (CTRL_RW),
        .CTRL_W1S  (CTRL_W1S),
        .CTRL_WO   (CTRL_WO),
        .FLAG_W1C  (FLAG_W1C)
    );

    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // One access; ack is registered on the taking edge and checked just after it
    task automatic access(input logic wr, input logic [11:0] ofs,
                          input logic [31:0] wd, output logic [31:0] r);
        @(posedge SYS_CLK);
        ACC_REQ <= '{1'b1, wr, BASE_ADDR + {20'h00000, ofs}, wd};
        @(posedge SYS_CLK);
        ACC_REQ <= '0;
        #1;
        check({31'h0, ACC_RSP.ack}, 32'h1);
        if (wr) check(ACC_RSP.rdata, 32'h0);
        r = ACC_RSP.rdata;
    endtask : access

    task automatic pulse(input rfa_pkg::rfa_hw_t e);
        @(posedge SYS_CLK);
        HW_EVT <= e;
        @(posedge SYS_CLK);
        HW_EVT <= '0;
        // Let the taking edge settle before anyone looks
        #1;
    endtask : pulse

    initial begin
        repeat (5000) @(posedge SYS_CLK);
        miscompares++;
        wrap_up();
    end

    initial begin
        miscompares = 0;
        samples_checked = 0;
        RESET = 1'b1;
        ACC_REQ = '0;
        HW_EVT = '0;
        HW_STATUS = 16'h3C3C;
        repeat (2) @(posedge SYS_CLK);
        RESET <= 1'b0;
        for (int i = 0; i < 22; i++) begin
            access(ROWS[i].wr, ROWS[i].ofs, ROWS[i].wd, rd);
            if (!ROWS[i].wr) check(rd, ROWS[i].exp);
        end
        check({16'h0, CTRL_WO}, 32'h0000_5A5A);
        check({16'h0, CTRL_RW}, 32'h0000_00FF);
        check({16'h0, CTRL_W1S}, 32'h0000_00F1);
        // Clear-on-read: value once, then gone
        ev = '0;
        ev.rc_set = 16'h0011;
        pulse(ev);
        access(1'b0, rfa_pkg::OFS_RC, 32'h0, rd);
        check(rd, 32'h0000_0011);
        access(1'b0, rfa_pkg::OFS_RC, 32'h0, rd);
        check(rd, 32'h0);
        // Set in the same cycle as the read survives the clear
        ev = '0;
        ev.rc_set = 16'h0022;
        fork
            pulse(ev);
            access(1'b0, rfa_pkg::OFS_RC, 32'h0, rd);
        join
        check(rd, 32'h0);
        access(1'b0, rfa_pkg::OFS_RC, 32'h0, rd);
        check(rd, 32'h0000_0022);
        // Clear on any write, even all zeros
        ev = '0;
        ev.rwc_set = 16'h0F00;
        pulse(ev);
        access(1'b0, rfa_pkg::OFS_RWC, 32'h0, rd);
        check(rd, 32'h0000_0F00);
        access(1'b1, rfa_pkg::OFS_RWC, 32'h0, rd);
        access(1'b0, rfa_pkg::OFS_RWC, 32'h0, rd);
        check(rd, 32'h0);
        // Partial clear, then write-back of the read value
        ev = '0;
        ev.rw1c_set = 16'h00FF;
        pulse(ev);
        access(1'b1, rfa_pkg::OFS_RW1C, 32'h0000_000F, rd);
        access(1'b0, rfa_pkg::OFS_RW1C, 32'h0, rd);
        check(rd, 32'h0000_00F0);
        access(1'b1, rfa_pkg::OFS_RW1C, rd, rd);
        access(1'b0, rfa_pkg::OFS_RW1C, 32'h0, rd);
        check(rd, 32'h0);
        // Write-only flags seen on the pins only
        ev = '0;
        ev.w1c_set = 16'h8001;
        pulse(ev);
        check({16'h0, FLAG_W1C}, 32'h0000_8001);
        access(1'b1, rfa_pkg::OFS_W1C, 32'h0000_0000, rd);
        check({16'h0, FLAG_W1C}, 32'h0000_8001);
        access(1'b1, rfa_pkg::OFS_W1C, 32'h0000_0001, rd);
        check({16'h0, FLAG_W1C}, 32'h0000_8000);
        // Hardware clear of the set-only field
        ev = '0;
        ev.rw1s_clr = 16'h00F0;
        pulse(ev);
        access(1'b0, rfa_pkg::OFS_RW1S, 32'h0, rd);
        check(rd, 32'h0000_0001);
        // Software set wins over a hardware clear in one cycle
        ev = '0;
        ev.rw1s_clr = 16'h0003;
        fork
            pulse(ev);
            access(1'b1, rfa_pkg::OFS_RW1S, 32'h0000_0002, rd);
        join
        access(1'b0, rfa_pkg::OFS_RW1S, 32'h0, rd);
        check(rd, 32'h0000_0002);
        // Reset in mid-run with state pending in all but the clear-on-write and write-one-to-clear fields
        ev = '0;
        ev.rc_set = 16'h0044;
        pulse(ev);
        @(posedge SYS_CLK);
        RESET <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        RESET <= 1'b0;
        #1;
        check({16'h0, CTRL_RW}, 32'h0000_00A5);
        check({16'h0, CTRL_W1S}, 32'h0000_0001);
        check({16'h0, CTRL_WO}, 32'h0);
        check({16'h0, FLAG_W1C}, 32'h0);
        check({31'h0, ACC_RSP.ack}, 32'h0);
        access(1'b0, rfa_pkg::OFS_RC, 32'h0, rd);
        check(rd, 32'h0);
        wrap_up();
    end
endmodule : rfa_bank_bench
